// File: lit_map.svh
// register offsets, field positions, reset values and timing counts of the trim register bank
`ifndef LIT_MAP_SVH
`define LIT_MAP_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define LIT_OFS_CTRL1       8'h60
`define LIT_OFS_CTRL2       8'h61
`define LIT_OFS_RING        8'h62
`define LIT_OFS_TIP         8'h63
`define LIT_OFS_DIFF        8'h64
`define LIT_OFS_CM          8'h65
`define LIT_OFS_ILIM        8'h66
`define LIT_OFS_MON         8'h67
`define LIT_OFS_ANA         8'h68

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LIT_BIT_FULL        6
`define LIT_BIT_SPEEDUP     5
`define LIT_SEL_MSB         4
`define LIT_NUM_CAL         10

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LIT_RST_RING        5'h10
`define LIT_RST_TIP         5'h10
`define LIT_RST_DIFF        5'h00
`define LIT_RST_CM          5'h11
`define LIT_RST_ILIM        4'h8
`define LIT_RST_MON         8'h00
`define LIT_RST_ANA         4'h0

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define LIT_CLK_KHZ         200000
`define LIT_SETTLE_LONG_MS  300
`define LIT_SETTLE_SHORT_MS 30
`define LIT_SETTLE_LONG_CYC (`LIT_SETTLE_LONG_MS * `LIT_CLK_KHZ)
`define LIT_SETTLE_SHORT_CYC (`LIT_SETTLE_SHORT_MS * `LIT_CLK_KHZ)

`endif

// File: lit_pkg.sv
// types shared by the trim register bank
`default_nettype none

package lit_pkg;

   // ----------------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      LIT_IDLE,
      LIT_SETTLE,
      LIT_RUN,
      LIT_WAIT
   } lit_state_t;

endpackage

`default_nettype wire

// File: lit_settle_timer.sv
// battery settling timer with long and short wait
`timescale 1ns/100ps
`default_nettype none

module lit_settle_timer #(
   parameter int unsigned LONG_CYC = 60000000,
   parameter int unsigned SHORT_CYC = 6000000
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic start,
   input wire logic speedup,
   // status
   output logic busy,
   output logic done
);

   logic [31:0] cnt_reg;
   logic busy_reg;

   // ----------------------------------------------------------------------
   // countdown
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_reg <= 32'h00000000;
      end else if (start) begin
         cnt_reg <= speedup ? 32'(SHORT_CYC - 1) : 32'(LONG_CYC - 1);
      end else if (busy_reg && cnt_reg != 32'h00000000) begin
         cnt_reg <= cnt_reg - 32'h00000001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         busy_reg <= 1'b0;
      end else if (start) begin
         busy_reg <= 1'b1;
      end else if (busy_reg && cnt_reg == 32'h00000000) begin
         busy_reg <= 1'b0;
      end
   end

   assign busy = busy_reg;
   assign done = busy_reg && cnt_reg == 32'h00000000 && !start;

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   property p_settle_load;
      @(posedge clk) disable iff (rst)
      start |=> cnt_reg == ($past(speedup) ? 32'(SHORT_CYC - 1) : 32'(LONG_CYC - 1));
   endproperty
   a_settle_load: assert property (p_settle_load) else $error("settle count loaded wrong");

endmodule

`default_nettype wire

// File: lit_trim_regs.sv
// calibration control, status and trim result registers with calibration sequencer
// Summary of operation
// - writing one to bit 6 of control 1 starts a full system calibration
// - bit 6 reads one while full calibration runs, zero when finished
// - battery settling wait is 300 ms, or 30 ms when speedup bit set
// - each trim select bit reads one while enabled or running, cleared on completion
// - control 1 bit 4 selects ring gain mismatch calibration
// - control 1 bit 3 selects tip gain mismatch calibration
// - control 1 bit 2 selects differential dac gain calibration
// - control 1 bit 1 selects common mode dac gain calibration
// - control 2 bits 4 and 3 select monitor adc calibrations one and two
// - control 2 bit 2 starts voice dac offset calibration, reads one until done
// - control 2 bit 1 starts voice adc offset calibration, reads one until done
// - control 2 bit 0 starts longitudinal balance calibration, reads one until done
// - ring mismatch result is 5 bits at 4:0, reset 0x10
// - tip mismatch result is 5 bits at 4:0, reset 0x10
// - differential dac gain result is 5 bits at 4:0
// - common mode dac gain result is 5 bits at 4:0, reset 0x11
// - current limit result is 4 bits at 3:0, reset 0x08
// - monitor offsets: first at 7:4, second at 3:0, both writable
// - analog offset bits 3..0 writable, reset zero
// - reserved bits read zero, writes to them ignored
`timescale 1ns/100ps
`default_nettype none
`include "lit_map.svh"

module lit_trim_regs #(
   parameter int unsigned SETTLE_LONG_CYC = `LIT_SETTLE_LONG_CYC,
   parameter int unsigned SETTLE_SHORT_CYC = `LIT_SETTLE_SHORT_CYC,
   parameter int unsigned NUM_CAL = `LIT_NUM_CAL
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // analog calibration engines
   output logic [NUM_CAL-1:0] cal_req,
   output logic settle_active,
   input wire logic cal_done,
   input wire logic [4:0] cal_value,
   // trim values to the analog side
   output logic [4:0] ring_mismatch_value,
   output logic [4:0] tip_mismatch_value,
   output logic [4:0] diff_gain_value,
   output logic [4:0] cm_gain_value,
   output logic [3:0] current_limit_value,
   output logic [3:0] monitor_offset_value1,
   output logic [3:0] monitor_offset_value2,
   output logic converter_out_offset_pos,
   output logic converter_out_offset_neg,
   output logic converter_in_offset_pos,
   output logic converter_in_offset_neg
);

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [3:0] lowest_set(input logic [NUM_CAL-1:0] v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int i = NUM_CAL - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = 4'(i);
         end
      end
      return idx;
   endfunction

   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      return a == ofs;
   endfunction

   // ----------------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------------
   lit_pkg::lit_state_t state_reg;
   logic full_reg;
   logic speedup_reg;
   logic [NUM_CAL-1:0] sel_reg;
   logic [NUM_CAL-1:0] sel_next;
   logic [NUM_CAL-1:0] sel_set;
   logic [NUM_CAL-1:0] sel_clr;
   logic [3:0] act_reg;
   logic [NUM_CAL-1:0] req_reg;
   logic [4:0] ring_reg;
   logic [4:0] tip_reg;
   logic [4:0] diff_reg;
   logic [4:0] cm_reg;
   logic [3:0] ilim_reg;
   logic [7:0] mon_reg;
   logic [3:0] ana_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rd_mux;
   logic wr1;
   logic wr2;
   logic full_set;
   logic any_set;
   logic done_hit;
   logic timer_start;
   logic timer_busy;
   logic timer_done;
   logic speedup_now;

   // ----------------------------------------------------------------------
   // write decode
   // ----------------------------------------------------------------------
   assign wr1 = reg_wr && hit(reg_addr, `LIT_OFS_CTRL1);
   assign wr2 = reg_wr && hit(reg_addr, `LIT_OFS_CTRL2);
   assign full_set = wr1 && reg_wdata[`LIT_BIT_FULL];
   assign done_hit = state_reg == lit_pkg::LIT_WAIT && cal_done;
   // speedup written together with a start applies to that start
   assign speedup_now = wr1 ? reg_wdata[`LIT_BIT_SPEEDUP] : speedup_reg;

   always_comb begin
      sel_set = '0;
      sel_clr = '0;
      if (full_set) begin
         sel_set = '1;
      end
      if (wr1) begin
         sel_set[4:0] = sel_set[4:0] | reg_wdata[`LIT_SEL_MSB:0];
      end
      if (wr2) begin
         sel_set[9:5] = reg_wdata[`LIT_SEL_MSB:0];
      end
      if (done_hit) begin
         sel_clr[act_reg] = 1'b1;
      end
      sel_next = (sel_reg & ~sel_clr) | sel_set;
   end

   assign any_set = |sel_set;
   assign timer_start = state_reg == lit_pkg::LIT_IDLE && any_set;

   // ----------------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= lit_pkg::LIT_IDLE;
      end else begin
         case (state_reg)
            lit_pkg::LIT_IDLE: begin
               if (any_set) begin
                  state_reg <= lit_pkg::LIT_SETTLE;
               end
            end
            lit_pkg::LIT_SETTLE: begin
               if (timer_done) begin
                  state_reg <= lit_pkg::LIT_RUN;
               end
            end
            lit_pkg::LIT_RUN: begin
               if (sel_reg == '0 && !any_set) begin
                  state_reg <= lit_pkg::LIT_IDLE;
               end else if (sel_reg != '0) begin
                  state_reg <= lit_pkg::LIT_WAIT;
               end
            end
            lit_pkg::LIT_WAIT: begin
               if (cal_done) begin
                  state_reg <= lit_pkg::LIT_RUN;
               end
            end
            default: begin
               state_reg <= lit_pkg::LIT_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         act_reg <= 4'h0;
         req_reg <= '0;
      end else if (state_reg == lit_pkg::LIT_RUN && sel_reg != '0) begin
         act_reg <= lowest_set(sel_reg);
         req_reg <= NUM_CAL'(1) << lowest_set(sel_reg);
      end else if (done_hit) begin
         req_reg <= '0;
      end
   end

   // ----------------------------------------------------------------------
   // control and status bits
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         sel_reg <= '0;
      end else begin
         sel_reg <= sel_next;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         full_reg <= 1'b0;
      end else if (full_set) begin
         full_reg <= 1'b1;
      end else if (state_reg == lit_pkg::LIT_RUN && sel_reg == '0 && !any_set) begin
         full_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         speedup_reg <= 1'b0;
      end else if (wr1) begin
         speedup_reg <= reg_wdata[`LIT_BIT_SPEEDUP];
      end
   end

   // ----------------------------------------------------------------------
   // result fields
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         ring_reg <= `LIT_RST_RING;
         tip_reg <= `LIT_RST_TIP;
         diff_reg <= `LIT_RST_DIFF;
         cm_reg <= `LIT_RST_CM;
         ilim_reg <= `LIT_RST_ILIM;
         mon_reg <= `LIT_RST_MON;
      end else begin
         if (reg_wr) begin
            if (hit(reg_addr, `LIT_OFS_RING)) begin
               ring_reg <= reg_wdata[4:0];
            end
            if (hit(reg_addr, `LIT_OFS_TIP)) begin
               tip_reg <= reg_wdata[4:0];
            end
            if (hit(reg_addr, `LIT_OFS_DIFF)) begin
               diff_reg <= reg_wdata[4:0];
            end
            if (hit(reg_addr, `LIT_OFS_CM)) begin
               cm_reg <= reg_wdata[4:0];
            end
            if (hit(reg_addr, `LIT_OFS_ILIM)) begin
               ilim_reg <= reg_wdata[3:0];
            end
            if (hit(reg_addr, `LIT_OFS_MON)) begin
               mon_reg <= reg_wdata;
            end
         end
         // a finishing calibration overrides only a write to its own field
         if (done_hit) begin
            case (act_reg)
               4'h0: ilim_reg <= cal_value[3:0];
               4'h1: cm_reg <= cal_value;
               4'h2: diff_reg <= cal_value;
               4'h3: tip_reg <= cal_value;
               4'h4: ring_reg <= cal_value;
               4'h8: mon_reg[3:0] <= cal_value[3:0];
               4'h9: mon_reg[7:4] <= cal_value[3:0];
               default: begin
               end
            endcase
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ana_reg <= `LIT_RST_ANA;
      end else if (reg_wr && hit(reg_addr, `LIT_OFS_ANA)) begin
         ana_reg <= reg_wdata[3:0];
      end
   end

   // ----------------------------------------------------------------------
   // read back
   // ----------------------------------------------------------------------
   always_comb begin
      rd_mux = 8'h00;
      case (reg_addr)
         `LIT_OFS_CTRL1: rd_mux = {1'b0, full_reg, speedup_reg, sel_reg[4:0]};
         `LIT_OFS_CTRL2: rd_mux = {3'h0, sel_reg[9:5]};
         `LIT_OFS_RING: rd_mux = {3'h0, ring_reg};
         `LIT_OFS_TIP: rd_mux = {3'h0, tip_reg};
         `LIT_OFS_DIFF: rd_mux = {3'h0, diff_reg};
         `LIT_OFS_CM: rd_mux = {3'h0, cm_reg};
         `LIT_OFS_ILIM: rd_mux = {4'h0, ilim_reg};
         `LIT_OFS_MON: rd_mux = mon_reg;
         `LIT_OFS_ANA: rd_mux = {4'h0, ana_reg};
         default: rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd) begin
         rdata_reg <= rd_mux;
      end
   end

   // ----------------------------------------------------------------------
   // settling timer
   // ----------------------------------------------------------------------
   lit_settle_timer #(
      .LONG_CYC(SETTLE_LONG_CYC),
      .SHORT_CYC(SETTLE_SHORT_CYC)
   ) u_settle (
      .clk(clk),
      .rst(rst),
      .start(timer_start),
      .speedup(speedup_now),
      .busy(timer_busy),
      .done(timer_done)
   );

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign reg_rdata = rdata_reg;
   assign cal_req = req_reg;
   assign settle_active = timer_busy;
   assign ring_mismatch_value = ring_reg;
   assign tip_mismatch_value = tip_reg;
   assign diff_gain_value = diff_reg;
   assign cm_gain_value = cm_reg;
   assign current_limit_value = ilim_reg;
   assign monitor_offset_value1 = mon_reg[7:4];
   assign monitor_offset_value2 = mon_reg[3:0];
   assign converter_out_offset_pos = ana_reg[3];
   assign converter_out_offset_neg = ana_reg[2];
   assign converter_in_offset_pos = ana_reg[1];
   assign converter_in_offset_neg = ana_reg[0];

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_full_start;
      state_reg == lit_pkg::LIT_IDLE && full_set;
   endsequence

   sequence s_enter_settle;
      state_reg == lit_pkg::LIT_SETTLE && full_reg && sel_reg == '1;
   endsequence

   property p_full_start;
      s_full_start |=> s_enter_settle;
   endproperty
   a_full_start: assert property (p_full_start) else $error("full start not taken");

   property p_full_clear;
      state_reg == lit_pkg::LIT_IDLE && !any_set |-> !full_reg;
   endproperty
   a_full_clear: assert property (p_full_clear) else $error("full bit set while idle");

   property p_sel_clear;
      done_hit && !sel_set[act_reg] |=> !sel_reg[$past(act_reg)] && cal_req == '0;
   endproperty
   a_sel_clear: assert property (p_sel_clear) else $error("select bit not cleared");

   property p_dac_start;
      state_reg == lit_pkg::LIT_IDLE && wr2 && reg_wdata[2]
         |=> sel_reg[7] && state_reg == lit_pkg::LIT_SETTLE;
   endproperty
   a_dac_start: assert property (p_dac_start) else $error("dac offset start lost");

   property p_ring_result;
      done_hit && act_reg == 4'h4 |=> ring_reg == $past(cal_value);
   endproperty
   a_ring_result: assert property (p_ring_result) else $error("ring result not stored");

   property p_ring_read;
      reg_rd && reg_addr == `LIT_OFS_RING |=> reg_rdata == {3'h0, $past(ring_reg)};
   endproperty
   a_ring_read: assert property (p_ring_read) else $error("ring read wrong");

   property p_ctrl1_rsvd;
      reg_rd && reg_addr == `LIT_OFS_CTRL1 |=> reg_rdata[7] == 1'b0;
   endproperty
   a_ctrl1_rsvd: assert property (p_ctrl1_rsvd) else $error("reserved bit not zero");

   property p_ana_write;
      reg_wr && reg_addr == `LIT_OFS_ANA |=> {converter_out_offset_pos, converter_out_offset_neg,
         converter_in_offset_pos, converter_in_offset_neg} == $past(reg_wdata[3:0]);
   endproperty
   a_ana_write: assert property (p_ana_write) else $error("analog offset write lost");

   property p_one_req;
      $onehot0(cal_req) && (state_reg == lit_pkg::LIT_WAIT || cal_req == '0);
   endproperty
   a_one_req: assert property (p_one_req) else $error("calibration request malformed");

endmodule

`default_nettype wire

// File: tb_lit_trim_regs.sv
// self-checking testbench of the trim register bank
`timescale 1ns/100ps
`default_nettype none
`include "lit_map.svh"

module tb_lit_trim_regs;
   // ----------------------------------------------------------------------
   // signals and instance
   // ----------------------------------------------------------------------
   localparam int unsigned LONG_N = 20;
   localparam int unsigned SHORT_N = 5;
   localparam int LIMIT = 20000;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic cal_done = 1'b0;
   logic [4:0] cal_value = 5'h00;
   logic [7:0] reg_rdata;
   logic [9:0] cal_req;
   logic settle_active;
   logic [4:0] ring_v, tip_v, diff_v, cm_v;
   logic [3:0] ilim_v, mon1_v, mon2_v;
   logic dac_p, dac_n, adc_p, adc_n;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;

   lit_trim_regs #(.SETTLE_LONG_CYC(LONG_N), .SETTLE_SHORT_CYC(SHORT_N)) uut (
      .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .cal_req(cal_req),
      .settle_active(settle_active), .cal_done(cal_done), .cal_value(cal_value),
      .ring_mismatch_value(ring_v), .tip_mismatch_value(tip_v), .diff_gain_value(diff_v),
      .cm_gain_value(cm_v), .current_limit_value(ilim_v), .monitor_offset_value1(mon1_v),
      .monitor_offset_value2(mon2_v), .converter_out_offset_pos(dac_p),
      .converter_out_offset_neg(dac_n), .converter_in_offset_pos(adc_p),
      .converter_in_offset_neg(adc_n)
   );

   initial begin
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------------
   task automatic finish_test();
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         finish_test();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      #1;
      d = reg_rdata;
   endtask

   task automatic read_check(input logic [7:0] a, input logic [7:0] exp, input string msg);
      logic [7:0] d;
      reg_read(a, d);
      check({8'h00, d}, {8'h00, exp}, msg);
   endtask

   task automatic pulse_done(input logic [4:0] v);
      @(posedge clk);
      cal_done <= 1'b1;
      cal_value <= v;
      @(posedge clk);
      cal_done <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wait_req();
      for (int k = 0; k < 100; k++) begin
         @(posedge clk);
         #1;
         if (cal_req !== 10'h000) break;
      end
   endtask

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   task automatic test_reset_values();
      logic [7:0] e [9] = '{8'h00, 8'h00, 8'h10, 8'h10, 8'h00, 8'h11, 8'h08, 8'h00, 8'h00};
      for (int i = 0; i < 9; i++) begin
         read_check(8'h60 + i[7:0], e[i], "reset value");
      end
      check({11'h000, ring_v}, {11'h000, `LIT_RST_RING}, "ring trim out");
      check({11'h000, cm_v}, {11'h000, `LIT_RST_CM}, "cm trim out");
      check({12'h000, ilim_v}, {12'h000, `LIT_RST_ILIM}, "ilim trim out");
   endtask

   task automatic test_result_access();
      logic [7:0] e [7] = '{8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h0F, 8'hFF, 8'h0F};
      for (int i = 0; i < 7; i++) begin
         reg_write(8'h62 + i[7:0], 8'hFF);
      end
      reg_write(8'h69, 8'hFF);
      reg_write(8'h5F, 8'hFF);
      pulse_done(5'h03);
      for (int i = 0; i < 7; i++) begin
         read_check(8'h62 + i[7:0], e[i], "result readback");
      end
      read_check(8'h69, 8'h00, "unmapped above");
      read_check(8'h5F, 8'h00, "unmapped below");
      check({1'b0, ring_v, tip_v, diff_v}, 16'h7FFF, "5 bit trims out");
      check({4'h0, mon1_v, mon2_v, ilim_v}, 16'h0FFF, "4 bit trims out");
      check({12'h000, dac_p, dac_n, adc_p, adc_n}, 16'h000F, "offset bits out");
   endtask

   task automatic run_one(input int i, input logic sp);
      logic [7:0] a;
      logic [7:0] d;
      logic [4:0] v;
      int n;
      a = (i < 5) ? `LIT_OFS_CTRL1 : `LIT_OFS_CTRL2;
      v = 5'h0A + i[4:0];
      n = 0;
      reg_write(`LIT_OFS_CTRL1, {2'b00, sp, 5'h00});
      reg_write(a, (i < 5) ? {2'b00, sp, 5'h01 << i} : {3'b000, 5'h01 << (i - 5)});
      for (int k = 0; k < 100; k++) begin
         #1;
         if (settle_active === 1'b1) n++;
         else if (n > 0) break;
         @(posedge clk);
      end
      check(n[15:0], sp ? SHORT_N[15:0] : LONG_N[15:0], "settle length");
      wait_req();
      check({6'h00, cal_req}, {6'h00, 10'h001 << i}, "request index");
      reg_read(a, d);
      check({15'h0000, d[i % 5]}, 16'h0001, "select while running");
      pulse_done(v);
      reg_read(a, d);
      check({11'h000, d[4:0]}, 16'h0000, "select cleared");
      case (i)
         0: read_check(`LIT_OFS_ILIM, {4'h0, v[3:0]}, "ilim result");
         1: read_check(`LIT_OFS_CM, {3'b000, v}, "cm result");
         2: read_check(`LIT_OFS_DIFF, {3'b000, v}, "diff result");
         3: read_check(`LIT_OFS_TIP, {3'b000, v}, "tip result");
         4: read_check(`LIT_OFS_RING, {3'b000, v}, "ring result");
         8, 9: begin
            reg_read(`LIT_OFS_MON, d);
            check({12'h000, (i == 9) ? d[7:4] : d[3:0]}, {12'h000, v[3:0]}, "mon result");
         end
         default: ;
      endcase
   endtask

   task automatic test_single_cals();
      for (int i = 0; i < 10; i++) begin
         run_one(i, i[0]);
      end
   endtask

   task automatic test_full_cal();
      reg_write(`LIT_OFS_CTRL1, 8'h00);
      reg_write(`LIT_OFS_CTRL1, 8'h60);
      read_check(`LIT_OFS_CTRL1, 8'h7F, "full start status");
      read_check(`LIT_OFS_CTRL2, 8'h1F, "full start selects");
      check({15'h0000, settle_active}, 16'h0000, "speedup with start");
      for (int k = 0; k < 10; k++) begin
         wait_req();
         check({6'h00, cal_req}, {6'h00, 10'h001 << k}, "full order");
         pulse_done(5'h04);
      end
      repeat (5) @(posedge clk);
      read_check(`LIT_OFS_CTRL1, 8'h20, "full finished");
      read_check(`LIT_OFS_CTRL2, 8'h00, "full selects clear");
      read_check(`LIT_OFS_TIP, 8'h04, "full result");
   endtask

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      test_reset_values();
      test_result_access();
      test_single_cals();
      test_full_cal();
      finish_test();
   end
endmodule

`default_nettype wire
